// file: hdl/bchr_regs.sv
// bridge configuration header register bank, apb slave
//
// Operation
// - header type reads single-function bridge layout
// - self-test byte reads zero, ignores writes
// - base low 31:20 writable when enabled
// - base low bit 3 reads one
// - base low bits 2:1 read 10b
// - base low bit 0, 19:4 read zero
// - base high fully writable when enabled
// - upstream bus number read-write, reset zero
// - downstream bus number read-write, reset zero
// - highest bus number read-write, reset zero
// - latency timer resets 00h or 40h by mode
// - io base: writable nibble, fixed 01b
// - io limit: writable nibble, fixed 01b
// - status 31 set on parity error
// - status 30 set on system error
// - status 29 set on master abort
// - status 28 set on received target abort
// - status 27 set on signaled target abort
// - status 26:25 read 01
// - status 24 set on data parity error
// - status 23 reads inverse of pci-x mode
// - status 21 reads one, 22 and 20:16 zero
`timescale 1ns/10ps
`default_nettype none
module bchr_regs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // mode straps, same clock domain
    input  wire logic        pcix_mode_i,
    input  wire logic        bar_en_i,
    // downstream error events, one-cycle pulses
    input  wire logic        evt_parity_i,
    input  wire logic        evt_sys_err_i,
    input  wire logic        evt_master_abort_i,
    input  wire logic        evt_rx_target_abort_i,
    input  wire logic        evt_tx_target_abort_i,
    input  wire logic        evt_data_parity_i,
    // window values for forwarding logic
    output logic      [63:20] mem_base_o,
    output logic      [7:0]  upstream_bus_o,
    output logic      [7:0]  downstream_bus_o,
    output logic      [7:0]  highest_bus_o,
    output logic      [7:0]  latency_timer_o,
    output logic      [3:0]  io_base_o,
    output logic      [3:0]  io_limit_o
);
    import bchr_pkg::*;

    function automatic logic [31:0] bchr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : bchr_merge

    logic [31:20] base_lo;
    logic [31:0]  base_hi;
    logic [31:0]  busnum;
    logic [3:0]   io_base;
    logic [3:0]   io_limit;
    logic [15:0]  st_flags;
    logic         in_reset_d;
    logic         pready_q;

    // apb: access phase answered in one cycle with zero wait states
    wire          acc      = psel_i & penable_i;
    wire          wr_acc   = acc & pwrite_i;
    wire          hit_hdr  = (paddr_i[11:2] == BCHR_OFS_HDR[11:2]);
    wire          hit_blo  = (paddr_i[11:2] == BCHR_OFS_BASELO[11:2]);
    wire          hit_bhi  = (paddr_i[11:2] == BCHR_OFS_BASEHI[11:2]);
    wire          hit_bus  = (paddr_i[11:2] == BCHR_OFS_BUSNUM[11:2]);
    wire          hit_ios  = (paddr_i[11:2] == BCHR_OFS_IOSTAT[11:2]);
    wire          hit_any  = hit_hdr | hit_blo | hit_bhi | hit_bus | hit_ios;
    wire          wr_blo   = wr_acc & hit_blo & bar_en_i;
    wire          wr_bhi   = wr_acc & hit_bhi & bar_en_i;
    wire          wr_bus   = wr_acc & hit_bus;
    wire          wr_ios   = wr_acc & hit_ios;

    wire [31:0] blo_word = {bar_en_i ? base_lo : 12'h000, BCHR_BASELO_FIX};
    wire [31:0] bhi_word = bar_en_i ? base_hi : 32'h0000_0000;
    wire [31:0] hdr_word = {BCHR_SELF_TEST, BCHR_HDR_LAYOUT, BCHR_OTHER_0C_W};
    wire [15:0] st_word  = st_flags | BCHR_ST_FIXED
                         | (16'(!pcix_mode_i) << BCHR_ST_FBB);
    wire [31:0] ios_word = {st_word, io_limit, 4'(BCHR_IO_FIX),
                            io_base, 4'(BCHR_IO_FIX)};

    wire [31:0] blo_new  = bchr_merge(blo_word, pwdata_i, pstrb_i);
    wire [31:0] bhi_new  = bchr_merge(base_hi, pwdata_i, pstrb_i);
    wire [31:0] bus_new  = bchr_merge(busnum, pwdata_i, pstrb_i);
    wire [31:0] ios_new  = bchr_merge(ios_word, pwdata_i, pstrb_i);

    // write-one-clear uses only lanes enabled in the upper half
    wire [15:0] st_clr   = wr_ios ? (pwdata_i[31:16] & {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}}
                                     & BCHR_ST_W1C) : 16'h0000;
    wire [BCHR_NEVT-1:0] evts = {evt_parity_i, evt_sys_err_i, evt_master_abort_i,
                                 evt_rx_target_abort_i, evt_tx_target_abort_i,
                                 evt_data_parity_i};
    wire [15:0] st_set   = (16'(evts[5]) << BCHR_ST_DPE)
                         | (16'(evts[4]) << BCHR_ST_SSE)
                         | (16'(evts[3]) << BCHR_ST_RMA)
                         | (16'(evts[2]) << BCHR_ST_RTA)
                         | (16'(evts[1]) << BCHR_ST_STA)
                         | (16'(evts[0]) << BCHR_ST_MDPE);
    wire [15:0] next_st  = (st_flags & ~st_clr) | st_set;

    wire [31:0] rd_mux   = hit_hdr ? hdr_word :
                           hit_blo ? blo_word :
                           hit_bhi ? bhi_word :
                           hit_bus ? busnum   :
                           hit_ios ? ios_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            base_lo    <= 12'h000;
            base_hi    <= 32'h0000_0000;
            busnum     <= {BCHR_LAT_RST_C, BCHR_BUS_RST, BCHR_BUS_RST, BCHR_BUS_RST};
            io_base    <= BCHR_IO_RST;
            io_limit   <= BCHR_IO_RST;
            st_flags   <= 16'h0000;
            in_reset_d <= 1'b1;
        end else begin
            in_reset_d <= 1'b0;
            if (in_reset_d) begin
                busnum[31:24] <= pcix_mode_i ? BCHR_LAT_RST_X : BCHR_LAT_RST_C;
            end else if (wr_bus) begin
                busnum <= bus_new;
            end
            if (wr_blo) begin
                base_lo <= blo_new[31:BCHR_BASE_LSB];
            end
            if (wr_bhi) begin
                base_hi <= bhi_new;
            end
            if (wr_ios) begin
                io_base  <= ios_new[7:4];
                io_limit <= ios_new[15:12];
            end
            st_flags <= next_st;
        end
    end

    // read data registered at setup, so access phase needs no wait
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_q  <= 1'b0;
        end else begin
            pready_q  <= psel_i & ~penable_i;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_o <= rd_mux;
            end
        end
    end

    assign pready_o         = acc & pready_q;
    assign pslverr_o        = acc & pready_q & ~hit_any;
    assign mem_base_o       = {bhi_word, blo_word[31:BCHR_BASE_LSB]};
    assign upstream_bus_o   = busnum[7:0];
    assign downstream_bus_o = busnum[15:8];
    assign highest_bus_o    = busnum[23:16];
    assign latency_timer_o  = busnum[31:24];
    assign io_base_o        = io_base;
    assign io_limit_o       = io_limit;

    // assertions
    property p_set_wins;
        @(posedge clk_i) disable iff (srst_i)
        evt_parity_i |=> st_flags[BCHR_ST_DPE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("parity flag lost");

    property p_sse;
        @(posedge clk_i) disable iff (srst_i)
        evt_sys_err_i |=> st_flags[BCHR_ST_SSE];
    endproperty
    a_sse: assert property (p_sse) else $error("system error flag not set");

    property p_clear;
        @(posedge clk_i) disable iff (srst_i)
        (wr_ios && pstrb_i[3] && pwdata_i[29] && !evt_master_abort_i)
        |=> !st_flags[BCHR_ST_RMA];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_hold;
        @(posedge clk_i) disable iff (srst_i)
        (!wr_ios && !evt_rx_target_abort_i) |=> $stable(st_flags[BCHR_ST_RTA]);
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed without cause");

    property p_fixed_st;
        @(posedge clk_i) disable iff (srst_i)
        ios_word[26:25] == 2'b01 && ios_word[21] && !ios_word[22]
        && ios_word[20:16] == 5'h00 && ios_word[23] == !pcix_mode_i;
    endproperty
    a_fixed_st: assert property (p_fixed_st) else $error("fixed status bits wrong");

    property p_blo;
        @(posedge clk_i) disable iff (srst_i)
        blo_word[19:0] == 20'h0000c && (bar_en_i || blo_word[31:20] == 12'h000);
    endproperty
    a_blo: assert property (p_blo) else $error("base low fixed bits wrong");

    property p_bhi;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bhi && pstrb_i == 4'hf) |=> bhi_word == $past(pwdata_i);
    endproperty
    a_bhi: assert property (p_bhi) else $error("base high write lost");

    property p_lat;
        @(posedge clk_i)
        (srst_i ##1 !srst_i) |=> latency_timer_o == ($past(pcix_mode_i) ? 8'h40 : 8'h00);
    endproperty
    a_lat: assert property (p_lat) else $error("latency reset value wrong");

    property p_be;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bus && !pstrb_i[0]) |=> $stable(upstream_bus_o);
    endproperty
    a_be: assert property (p_be) else $error("unselected byte written");

    // read answer as the host samples it; data was latched at setup
    wire rd_done = pready_o & ~pwrite_i;

    property p_rma;
        @(posedge clk_i) disable iff (srst_i)
        evt_master_abort_i |=> st_flags[BCHR_ST_RMA];
    endproperty
    a_rma: assert property (p_rma) else $error("master abort flag not set");

    property p_rta;
        @(posedge clk_i) disable iff (srst_i)
        evt_rx_target_abort_i |=> st_flags[BCHR_ST_RTA];
    endproperty
    a_rta: assert property (p_rta) else $error("received abort flag not set");

    property p_sta;
        @(posedge clk_i) disable iff (srst_i)
        evt_tx_target_abort_i |=> st_flags[BCHR_ST_STA];
    endproperty
    a_sta: assert property (p_sta) else $error("signaled abort flag not set");

    property p_mdpe;
        @(posedge clk_i) disable iff (srst_i)
        evt_data_parity_i |=> st_flags[BCHR_ST_MDPE];
    endproperty
    a_mdpe: assert property (p_mdpe) else $error("data parity flag not set");

    property p_flag_rst;
        @(posedge clk_i)
        srst_i |=> st_flags == 16'h0000;
    endproperty
    a_flag_rst: assert property (p_flag_rst)
        else $error("status flags survive reset");

    property p_bus_rst;
        @(posedge clk_i)
        srst_i |=> {highest_bus_o, downstream_bus_o, upstream_bus_o} == 24'h00_0000;
    endproperty
    a_bus_rst: assert property (p_bus_rst)
        else $error("bus numbers not reset");

    property p_hdr_rd;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_hdr) |-> prdata_o[31:16] == 16'h0001;
    endproperty
    a_hdr_rd: assert property (p_hdr_rd) else $error("header word read wrong");

    property p_blo_rd;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_blo) |-> prdata_o[19:0] == 20'h0000c;
    endproperty
    a_blo_rd: assert property (p_blo_rd) else $error("base low read wrong");

    property p_blo_off;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_blo && !$past(bar_en_i)) |-> prdata_o[31:20] == 12'h000;
    endproperty
    a_blo_off: assert property (p_blo_off) else $error("disabled base low not zero");

    property p_bhi_off;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_bhi && !$past(bar_en_i)) |-> prdata_o == 32'h0000_0000;
    endproperty
    a_bhi_off: assert property (p_bhi_off) else $error("disabled base high not zero");

    property p_blo_keep;
        @(posedge clk_i) disable iff (srst_i)
        (wr_acc && hit_blo && !bar_en_i) |=> $stable(base_lo);
    endproperty
    a_blo_keep: assert property (p_blo_keep) else $error("disabled base low written");

    property p_bhi_keep;
        @(posedge clk_i) disable iff (srst_i)
        (wr_acc && hit_bhi && !bar_en_i) |=> $stable(base_hi);
    endproperty
    a_bhi_keep: assert property (p_bhi_keep) else $error("disabled base high written");

    property p_up_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bus && pstrb_i[0]) |=> upstream_bus_o == $past(pwdata_i[7:0]);
    endproperty
    a_up_wr: assert property (p_up_wr) else $error("upstream bus write lost");

    property p_dn_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bus && pstrb_i[1]) |=> downstream_bus_o == $past(pwdata_i[15:8]);
    endproperty
    a_dn_wr: assert property (p_dn_wr) else $error("downstream bus write lost");

    property p_hi_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bus && pstrb_i[2]) |=> highest_bus_o == $past(pwdata_i[23:16]);
    endproperty
    a_hi_wr: assert property (p_hi_wr) else $error("highest bus write lost");

    property p_lat_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_bus && pstrb_i[3] && !in_reset_d) |=> latency_timer_o == $past(pwdata_i[31:24]);
    endproperty
    a_lat_wr: assert property (p_lat_wr) else $error("latency write lost");

    property p_lat_keep;
        @(posedge clk_i) disable iff (srst_i)
        (!wr_bus && !in_reset_d) |=> $stable(latency_timer_o);
    endproperty
    a_lat_keep: assert property (p_lat_keep) else $error("latency changed unasked");

    property p_iob_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_ios && pstrb_i[0]) |=> io_base_o == $past(pwdata_i[7:4]);
    endproperty
    a_iob_wr: assert property (p_iob_wr) else $error("io base write lost");

    property p_iol_wr;
        @(posedge clk_i) disable iff (srst_i)
        (wr_ios && pstrb_i[1]) |=> io_limit_o == $past(pwdata_i[15:12]);
    endproperty
    a_iol_wr: assert property (p_iol_wr) else $error("io limit write lost");

    property p_io_rd;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_ios) |-> prdata_o[3:0] == 4'h1 && prdata_o[11:8] == 4'h1;
    endproperty
    a_io_rd: assert property (p_io_rd) else $error("io fixed bits wrong");

    property p_st_rd;
        @(posedge clk_i) disable iff (srst_i)
        (rd_done && hit_ios) |-> prdata_o[26:25] == 2'b01 && prdata_o[22:16] == 7'h20
        && prdata_o[23] == !$past(pcix_mode_i);
    endproperty
    a_st_rd: assert property (p_st_rd) else $error("status read wrong");

    property p_w0_keep;
        @(posedge clk_i) disable iff (srst_i)
        (wr_ios && !(pstrb_i[3] && pwdata_i[31]) && !evt_parity_i)
        |=> $stable(st_flags[BCHR_ST_DPE]);
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("flag cleared unasked");
endmodule : bchr_regs
`default_nettype wire

// file: hdl/bchr_pkg.sv
// package: offsets, field layouts and reset values of the bridge header span
package bchr_pkg;
    // register byte offsets
    localparam logic [11:0] BCHR_OFS_HDR    = 12'h00c;
    localparam logic [11:0] BCHR_OFS_BASELO = 12'h010;
    localparam logic [11:0] BCHR_OFS_BASEHI = 12'h014;
    localparam logic [11:0] BCHR_OFS_BUSNUM = 12'h018;
    localparam logic [11:0] BCHR_OFS_IOSTAT = 12'h01c;
    // other fields of the word at 0x0c; outside this block, read as zero
    localparam logic [7:0]  BCHR_OTHER_0C   = 8'h00;
    localparam logic [15:0] BCHR_OTHER_0C_W = 16'h0000;
    // header layout byte, bits 23:16
    localparam logic [7:0]  BCHR_HDR_LAYOUT = 8'h01;
    localparam logic [7:0]  BCHR_SELF_TEST  = 8'h00;
    // lower memory base: fixed low bits 19:0
    localparam int          BCHR_BASE_LSB   = 20;
    localparam logic [19:0] BCHR_BASELO_FIX = 20'h0000c;
    // bus number / latency reset values
    localparam logic [7:0]  BCHR_BUS_RST    = 8'h00;
    localparam logic [7:0]  BCHR_LAT_RST_C  = 8'h00;
    localparam logic [7:0]  BCHR_LAT_RST_X  = 8'h40;
    // io base/limit nibble reset values and fixed low nibbles
    localparam logic [3:0]  BCHR_IO_FIX     = 4'h1;
    localparam logic [3:0]  BCHR_IO_RST     = 4'h0;
    // downstream status bit positions within the 16-bit field
    localparam int          BCHR_ST_DPE     = 15;
    localparam int          BCHR_ST_SSE     = 14;
    localparam int          BCHR_ST_RMA     = 13;
    localparam int          BCHR_ST_RTA     = 12;
    localparam int          BCHR_ST_STA     = 11;
    localparam int          BCHR_ST_MDPE    = 8;
    localparam int          BCHR_ST_FBB     = 7;
    // sticky flag mask and fixed read bits (devsel 01, 66 MHz capable)
    localparam logic [15:0] BCHR_ST_W1C     = 16'hf900;
    localparam logic [15:0] BCHR_ST_FIXED   = 16'h0220;
    localparam int          BCHR_NEVT       = 6;
endpackage : bchr_pkg

// file: tb/bchr_host.sv
// apb host model issuing configuration reads and writes
`timescale 1ns/10ps
`default_nettype none
module bchr_host (
    // clock
    input  wire logic        clk_i,
    // apb master side
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o,
    output logic      [3:0]  pstrb_o,
    input  wire logic        pready_i,
    // wait bound ran out
    output logic             hung_o
);
    initial begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o, hung_o} = '0;
    end
    // starts one edge late so a release never meets a new setup in one step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_o    <= 1'b1;
        pwrite_o  <= wr;
        paddr_o   <= a;
        pwdata_o  <= d;
        pstrb_o   <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 40);
        if (n >= 40) hung_o <= 1'b1;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : bchr_host
`default_nettype wire

// file: tb/bchr_regs_test.sv
// self-checking bench of the bridge header register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module bchr_regs_test;
    logic        clk_i = 0, srst_i = 1, pcix = 1, bar_en = 0;
    logic [5:0]  evt = '0;
    logic        psel, penable, pwrite, pready, pslverr, hung;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, w18, st;
    logic [3:0]  pstrb;
    wire  [63:20] mem_base;
    wire  [31:0] bus_o;
    wire  [7:0]  io_o;
    logic [32:0] exp_q[$], e;
    int          n_fail = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    bchr_host u_host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .pready_i(pready), .hung_o(hung));
    bchr_regs dut_u (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pcix_mode_i(pcix),
        .bar_en_i(bar_en), .evt_parity_i(evt[5]), .evt_sys_err_i(evt[4]),
        .evt_master_abort_i(evt[3]), .evt_rx_target_abort_i(evt[2]),
        .evt_tx_target_abort_i(evt[1]), .evt_data_parity_i(evt[0]), .mem_base_o(mem_base),
        .upstream_bus_o(bus_o[7:0]), .downstream_bus_o(bus_o[15:8]),
        .highest_bus_o(bus_o[23:16]), .latency_timer_o(bus_o[31:24]),
        .io_base_o(io_o[3:0]), .io_limit_o(io_o[7:4]));
    // read results are paired with the oldest note
    always @(posedge clk_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            `CHK("prdata", prdata, e[31:0])
            `CHK("pslverr", pslverr, e[32])
            if (paddr == 12'h010) `CHK("base_lo_out", mem_base[31:20], e[31:20])
            if (paddr == 12'h014) `CHK("base_hi_out", mem_base[63:32], e[31:0])
            if (paddr == 12'h018) `CHK("bus_out", bus_o, e[31:0])
            if (paddr == 12'h01c) `CHK("io_out", io_o, {e[15:12], e[7:4]})
        end
    end
    always @(posedge hung) begin
        n_fail++;
        summarize();
    end
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic er = 0);
        exp_q.push_back({er, x});
        u_host.xfer(1'b0, a, 32'h0, 4'h0);
    endtask : rd
    task automatic rst();
        srst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : rst
    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction : mrg
    task automatic summarize();
        $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    initial begin
        void'($urandom(32'h57989edc));
        rst();
        rd(12'h00c, 32'h0001_0000);
        u_host.xfer(1'b1, 12'h00c, 32'hffff_ffff, 4'hf);
        rd(12'h00c, 32'h0001_0000);
        rd(12'h040, 32'h0, 1'b1);
        $display("test header done");
        bar_en <= 1'b1;
        d = $urandom();
        u_host.xfer(1'b1, 12'h010, d, 4'hf);
        rd(12'h010, {d[31:20], 20'h0000c});
        u_host.xfer(1'b1, 12'h014, ~d, 4'hf);
        rd(12'h014, ~d);
        @(posedge clk_i) bar_en <= 1'b0;
        u_host.xfer(1'b1, 12'h010, ~d, 4'hf);
        u_host.xfer(1'b1, 12'h014, d, 4'hf);
        rd(12'h010, 32'h0000_000c);
        rd(12'h014, 32'h0);
        bar_en <= 1'b1;
        rd(12'h010, {d[31:20], 20'h0000c});
        rd(12'h014, ~d);
        $display("test base done");
        w18 = 32'h4000_0000;
        rd(12'h018, w18);
        for (int i = 0; i < 3; i++) begin
            d = $urandom();
            u_host.xfer(1'b1, 12'h018, d, 4'(i == 0 ? 4'h5 : i == 1 ? 4'ha : 4'hf));
            w18 = mrg(w18, d, 4'(i == 0 ? 4'h5 : i == 1 ? 4'ha : 4'hf));
            rd(12'h018, w18);
        end
        d = $urandom();
        u_host.xfer(1'b1, 12'h01c, d, 4'h3);
        st = {16'h0220, d[15:12], 4'h1, d[7:4], 4'h1};
        rd(12'h01c, st);
        $display("test bus and io done");
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i) evt <= 6'(1 << k);
            @(posedge clk_i) evt <= '0;
            st[24 + k + (k > 0 ? 2 : 0)] = 1'b1;
            rd(12'h01c, st);
        end
        u_host.xfer(1'b1, 12'h01c, 32'h0, 4'hc);
        rd(12'h01c, st);
        fork
            u_host.xfer(1'b1, 12'h01c, 32'hff00_0000, 4'h8);
            begin
                repeat (2) @(posedge clk_i);
                evt <= 6'h20;
                @(posedge clk_i) evt <= '0;
            end
        join
        st[31:24] = 8'h82;
        rd(12'h01c, st);
        $display("test status done");
        pcix <= 1'b0;
        rst();
        rd(12'h018, 32'h0);
        rd(12'h01c, 32'h02a0_0101);
        $display("test conventional done");
        summarize();
    end
endmodule : bchr_regs_test
`default_nettype wire
